// *** verilog/scl_pkg.sv ***
// constants and carrier types for the self-id capture and link control block
package scl_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int          DATA_W          = 32;
  localparam int          DEC_W           = 8;
  localparam logic [7:0]  HCC_OFF         = 8'h50;
  localparam logic [7:0]  SIDB_OFF        = 8'h64;
  localparam logic [7:0]  SIDC_OFF        = 8'h68;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          HCC_SRST_BIT    = 16;
  localparam int          HCC_LINK_BIT    = 17;
  localparam int          HCC_EWA_BIT     = 18;
  localparam int          SIDB_LSB        = 11;
  localparam int          SIDB_W          = 21;
  localparam int          SIDC_ERR_BIT    = 31;
  localparam int          SIDC_EPOCH_LSB  = 16;
  localparam int          SIDC_SIZE_LSB   = 2;
  localparam int          EPOCH_W         = 8;
  localparam int          SIZE_W          = 9;
  localparam logic [20:0] SIDB_RST        = 21'h0;
  localparam logic [7:0]  EPOCH_RST       = 8'h0;
  localparam logic [8:0]  SIZE_RST        = 9'h0;

  // ---------------------------------------------------------------
  // timing and buffering
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_PS   = 8000;
  localparam int          SRST_TIME_NS    = 32;
  localparam int          SRST_CYCLES     = (SRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int          SRST_CNT_W      = 3;
  localparam int          FIFO_DEPTH      = 8;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic bus_reset;
    logic sid_begin;
    logic sid_end;
    logic hw_error;
  } scl_link_evt_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } scl_dma_req_s;

  typedef enum logic [1:0] {
    SID_IDLE,
    SID_RECV,
    SID_DRAIN
  } scl_sid_state_e;

endpackage

// *** verilog/scl_fifo.sv ***
// parameterised flip-flop fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module scl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW:0]      wp_reg;
  logic [PW:0]      wp_next;
  logic [PW:0]      rp_reg;
  logic [PW:0]      rp_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // depth must be a power of two; the extra pointer bit tells full from empty
  assign empty     = (wp_reg == rp_reg);
  assign full      = (wp_reg[PW] != rp_reg[PW]) && (wp_reg[PW-1:0] == rp_reg[PW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_reg[rp_reg[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    if (flush) begin
      wp_next = '0;
      rp_next = '0;
    end else begin
      if (push) begin
        mem_next[wp_reg[PW-1:0]] = in_data;
        wp_next = wp_reg + 1'b1;
      end
      if (pop) begin
        rp_next = rp_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      mem_reg <= mem_next;
    end
  end

endmodule

// *** verilog/scl_top.sv ***
// self-id capture and link control register block behind an ahb-lite slave
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
module scl_top
  import scl_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  // link side events and self-id quadlet stream
  input  wire scl_link_evt_s      link_evt,
  input  wire logic               sid_valid,
  output logic                    sid_ready,
  input  wire logic [31:0]        sid_data,
  // host memory write port
  output logic                    dma_valid,
  input  wire logic               dma_ready,
  output scl_dma_req_s            dma_req,
  input  wire logic               dma_error,
  // link status
  output logic                    link_connected,
  output logic                    early_write_ack
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic                  link_reg,   link_next;
  logic                  ewa_reg,    ewa_next;
  logic [SRST_CNT_W-1:0] srst_reg,   srst_next;
  logic [SIDB_W-1:0]     base_reg,   base_next;
  logic [EPOCH_W-1:0]    epoch_reg,  epoch_next;
  logic [SIZE_W-1:0]     size_reg,   size_next;
  logic                  fault_reg,  fault_next;
  logic                  errp_reg,   errp_next;
  scl_sid_state_e        sid_reg,    sid_next;
  logic                  wr_reg,     wr_next;
  logic                  rd_reg,     rd_next;
  logic [DEC_W-1:0]      addr_reg,   addr_next;
  logic [31:0]           rdata_reg,  rdata_next;

  logic                  srst_busy;
  logic                  ev_ok;
  logic                  take;
  logic                  any_err;
  logic                  finish;
  logic                  fifo_flush;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic                  dma_fire;
  logic [31:0]           fifo_out;

  function automatic logic reg_hit(input logic [DEC_W-1:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave: writes zero-wait, reads one wait state
  // ---------------------------------------------------------------
  // read data is captured one cycle into the data phase so that a read right
  // after a write sees the value just written
  assign take      = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = !rd_reg;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  always_comb begin
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    addr_next  = addr_reg;
    rdata_next = rdata_reg;
    if (take) begin
      wr_next   = hwrite;
      rd_next   = !hwrite;
      addr_next = haddr[DEC_W-1:0];
    end
    if (rd_reg) begin
      rdata_next = 32'h0;
      if (reg_hit(addr_reg, HCC_OFF)) begin
        rdata_next[HCC_EWA_BIT]  = ewa_reg;
        rdata_next[HCC_LINK_BIT] = link_reg;
        rdata_next[HCC_SRST_BIT] = srst_busy;
      end else if (reg_hit(addr_reg, SIDB_OFF)) begin
        rdata_next[31:SIDB_LSB] = base_reg;
      end else if (reg_hit(addr_reg, SIDC_OFF)) begin
        rdata_next[SIDC_ERR_BIT] = fault_reg;
        rdata_next[SIDC_EPOCH_LSB +: EPOCH_W] = epoch_reg;
        rdata_next[SIDC_SIZE_LSB +: SIZE_W]   = size_reg;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      rdata_reg <= 32'h0;
    end else begin
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      addr_reg  <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // control register and soft reset
  // ---------------------------------------------------------------
  // only this block's registers return to reset values; configuration space
  // lives elsewhere and has no path from this counter
  assign srst_busy       = (srst_reg != '0);
  assign link_connected  = link_reg && !srst_busy;
  assign early_write_ack = ewa_reg;
  assign ev_ok           = link_connected;

  always_comb begin
    link_next = link_reg;
    ewa_next  = ewa_reg;
    base_next = base_reg;
    srst_next = srst_reg;
    if (srst_busy) begin
      srst_next = srst_reg - 1'b1;
      link_next = 1'b0;
      ewa_next  = 1'b0;
      base_next = SIDB_RST;
    end else if (wr_reg && reg_hit(addr_reg, HCC_OFF)) begin
      if (hwdata[HCC_SRST_BIT]) begin
        srst_next = SRST_CNT_W'(SRST_CYCLES);
        link_next = 1'b0;
        ewa_next  = 1'b0;
        base_next = SIDB_RST;
      end else begin
        link_next = hwdata[HCC_LINK_BIT];
        // software is trusted to change this only with the link off
        ewa_next  = hwdata[HCC_EWA_BIT];
      end
    end else if (wr_reg && reg_hit(addr_reg, SIDB_OFF)) begin
      base_next = hwdata[31:SIDB_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_reg <= 1'b0;
      ewa_reg  <= 1'b0;
      srst_reg <= '0;
      base_reg <= SIDB_RST;
    end else begin
      link_reg <= link_next;
      ewa_reg  <= ewa_next;
      srst_reg <= srst_next;
      base_reg <= base_next;
    end
  end

  // ---------------------------------------------------------------
  // self-id capture
  // ---------------------------------------------------------------
  // the fifo is flushed on soft reset and at each new reception so that stale
  // quadlets from an aborted capture never land in the new buffer
  assign dma_fire      = dma_valid && dma_ready;
  assign any_err       = (link_evt.hw_error && ev_ok) || dma_error;
  assign finish        = (sid_reg == SID_DRAIN) && !dma_valid;
  assign fifo_flush    = srst_busy || (ev_ok && link_evt.sid_begin);
  assign fifo_in_valid = sid_valid && ev_ok && (sid_reg == SID_RECV);
  assign sid_ready     = fifo_in_ready && ev_ok && (sid_reg == SID_RECV);
  assign dma_req.data  = fifo_out;
  assign dma_req.addr  = {base_reg, 11'h000} | {21'h0, size_reg, 2'b00};

  always_comb begin
    sid_next   = sid_reg;
    epoch_next = epoch_reg;
    size_next  = size_reg;
    fault_next = fault_reg;
    errp_next  = errp_reg;
    if (srst_busy) begin
      sid_next   = SID_IDLE;
      epoch_next = EPOCH_RST;
      size_next  = SIZE_RST;
      fault_next = 1'b0;
      errp_next  = 1'b0;
    end else begin
      if (ev_ok && link_evt.bus_reset) begin
        epoch_next = epoch_reg + 1'b1;
      end
      if (ev_ok && link_evt.sid_begin) begin
        sid_next  = SID_RECV;
        size_next = SIZE_RST;
        errp_next = 1'b0;
      end else begin
        if (dma_fire) begin
          size_next = size_reg + 1'b1;
        end
        case (sid_reg)
          SID_IDLE: begin
            sid_next = SID_IDLE;
          end
          SID_RECV: begin
            if (ev_ok && link_evt.sid_end) begin
              sid_next = SID_DRAIN;
            end
          end
          SID_DRAIN: begin
            if (finish) begin
              sid_next = SID_IDLE;
              if (!errp_reg) begin
                fault_next = 1'b0;
              end
            end
          end
          default: begin
            sid_next = SID_IDLE;
          end
        endcase
      end
      // an error in the same cycle as completion wins over the clear
      if (any_err) begin
        fault_next = 1'b1;
        errp_next  = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sid_reg   <= SID_IDLE;
      epoch_reg <= EPOCH_RST;
      size_reg  <= SIZE_RST;
      fault_reg <= 1'b0;
      errp_reg  <= 1'b0;
    end else begin
      sid_reg   <= sid_next;
      epoch_reg <= epoch_next;
      size_reg  <= size_next;
      fault_reg <= fault_next;
      errp_reg  <= errp_next;
    end
  end

  scl_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) scl_fifo_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (sid_data),
    .out_valid (dma_valid),
    .out_ready (dma_ready),
    .out_data  (fifo_out)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_srst_write;
    !srst_busy && wr_reg && reg_hit(addr_reg, HCC_OFF) && hwdata[HCC_SRST_BIT];
  endsequence

  sequence s_srst_hold;
    srst_busy[*4] ##1 !srst_busy;
  endsequence

  a_srst_readback: assert property (s_srst_write |=> s_srst_hold)
    else $error("soft reset bit did not stand for its full time");

  a_link_cleared: assert property (srst_busy |=> !link_reg && !link_connected)
    else $error("link enable survived a soft reset");

  a_srst_flush: assert property (s_srst_write ##1 srst_busy |=> !dma_valid && size_reg == 0)
    else $error("fifo or count not cleared by soft reset");

  a_link_disconnect: assert property (!link_reg |-> !sid_ready && !link_connected)
    else $error("self-id accepted while link disabled");

  a_epoch_wrap: assert property (ev_ok && link_evt.bus_reset
                                 |=> epoch_reg == $past(epoch_reg) + 8'h01)
    else $error("epoch did not advance by one");

  a_count_clear: assert property (ev_ok && link_evt.sid_begin |=> size_reg == 0)
    else $error("quadlet count not cleared at reception start");

  a_count_step: assert property (dma_fire && !srst_busy && !(ev_ok && link_evt.sid_begin)
                                 |=> size_reg == $past(size_reg) + 9'h001)
    else $error("quadlet count missed a written quadlet");

  a_dma_address: assert property (dma_valid |-> dma_req.addr[10:0] == {size_reg, 2'b00}
                                  && dma_req.addr[31:11] == base_reg)
    else $error("host write address not base plus count");

  a_fault_set: assert property (any_err && !srst_busy |=> fault_reg ##1 fault_reg)
    else $error("fault flag not set on error");

  a_fault_clear: assert property (finish && !errp_reg && !any_err && !srst_busy
                                  && !(ev_ok && link_evt.sid_begin)
                                  |=> !fault_reg)
    else $error("fault flag not cleared after clean reception");

  // each register has its own reserved pattern; base bits above bit 10 are live
  a_reserved_zero: assert property (rd_reg ##1 1'b1 |->
      (!reg_hit($past(addr_reg), SIDC_OFF)
       || (hrdata[30:24] == 7'h00 && hrdata[15:11] == 5'h00 && hrdata[1:0] == 2'h0))
      && (!reg_hit($past(addr_reg), HCC_OFF) || hrdata[15:0] == 16'h0000)
      && (!reg_hit($past(addr_reg), SIDB_OFF) || hrdata[10:0] == 11'h000))
    else $error("reserved bits read non-zero");

  a_count_readonly: assert property (wr_reg && reg_hit(addr_reg, SIDC_OFF) && !dma_fire
                                     && !fifo_flush && !any_err && !finish
                                     |=> $stable(size_reg) && $stable(fault_reg))
    else $error("software write changed the count register");

endmodule

// *** verif/scl_phy_model.sv ***
// far-side model: phy link events, self-id quadlet source and host memory
`timescale 1ns/1ps
module scl_phy_model
  import scl_pkg::*;
(
  // clock
  input  wire logic         hclk,
  // link side
  output scl_link_evt_s     link_evt,
  output logic              sid_valid,
  input  wire logic         sid_ready,
  output logic [31:0]       sid_data,
  // host memory
  input  wire logic         dma_valid,
  output logic              dma_ready,
  input  wire scl_dma_req_s dma_req,
  output logic              dma_error
);
  logic         slow;
  logic [3:0]   tick;
  scl_dma_req_s got_q[$];

  initial begin
    link_evt  = '0;
    sid_valid = 1'b0;
    sid_data  = 32'h0;
    dma_error = 1'b0;
    slow      = 1'b0;
    tick      = 4'h0;
  end

  // ---------------------------------------------------------------
  // host memory: prompt, or one accept in four when slow
  // ---------------------------------------------------------------
  assign dma_ready = !slow || (tick[1:0] == 2'h3);

  always @(posedge hclk) begin
    tick <= tick + 4'h1;
    if (dma_valid && dma_ready) begin
      got_q.push_back(dma_req);
    end
  end

  // ---------------------------------------------------------------
  // link events; every task is entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic pulse(input scl_link_evt_s e);
    link_evt <= e;
    @(posedge hclk);
    link_evt <= '0;
    @(posedge hclk);
  endtask

  task automatic err_pulse;
    dma_error <= 1'b1;
    @(posedge hclk);
    dma_error <= 1'b0;
    @(posedge hclk);
  endtask

  // bus reset first, then the frame: begin, quadlets, end
  task automatic frame(input int n, input logic bad);
    int k;
    int w;
    pulse(scl_link_evt_s'(4'b1000));
    pulse(scl_link_evt_s'(4'b0100));
    for (k = 0; k < n; k++) begin
      sid_valid <= 1'b1;
      sid_data  <= 32'h5e1f0000 + k;
      @(posedge hclk);
      for (w = 0; w < 100 && sid_ready !== 1'b1; w++) @(posedge hclk);
    end
    // released line shows the inverse so a stale value is never read as data
    sid_valid <= 1'b0;
    sid_data  <= ~sid_data;
    pulse(scl_link_evt_s'({3'b001, bad}));
  endtask
endmodule

// *** verif/selfid_capture_and_link_control_bench.sv ***
// self-checking bench for the self-id capture and link control block
`timescale 1ns/1ps
module selfid_capture_and_link_control_bench
  import scl_pkg::*;
;
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic          hwrite;
  logic          hreadyout;
  logic          hresp;
  logic          sid_valid;
  logic          sid_ready;
  logic          dma_valid;
  logic          dma_ready;
  logic          dma_error;
  logic          link_connected;
  logic          early_write_ack;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   haddr;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic [31:0]   sid_data;
  logic [31:0]   rd;
  scl_link_evt_s link_evt;
  scl_dma_req_s  dma_req;
  int            miscompares;
  int            n_checks;

  scl_top scl_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_evt(link_evt),
    .sid_valid(sid_valid), .sid_ready(sid_ready), .sid_data(sid_data),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_req(dma_req),
    .dma_error(dma_error), .link_connected(link_connected),
    .early_write_ack(early_write_ack)
  );

  scl_phy_model scl_phy_model_i (
    .hclk(hclk), .link_evt(link_evt), .sid_valid(sid_valid), .sid_ready(sid_ready),
    .sid_data(sid_data), .dma_valid(dma_valid), .dma_ready(dma_ready),
    .dma_req(dma_req), .dma_error(dma_error)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ---------------------------------------------------------------
  // bus master and compare helpers, entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(what, e, rd);
  endtask

  // one capture with the host checked write by write, then the count read back
  task automatic run(input int n, input logic bad, input logic s, input logic [7:0] ep);
    int k;
    scl_phy_model_i.slow = s;
    scl_phy_model_i.got_q.delete();
    scl_phy_model_i.frame(n, bad);
    for (k = 0; k < 300 && scl_phy_model_i.got_q.size() < n; k++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk("writes", n, scl_phy_model_i.got_q.size());
    for (k = 0; k < scl_phy_model_i.got_q.size(); k++) begin
      chk("addr", 32'h00012800 + 4 * k, scl_phy_model_i.got_q[k].addr);
      chk("data", 32'h5e1f0000 + k, scl_phy_model_i.got_q[k].data);
    end
    rdc("count", SIDC_OFF, {bad, 7'h0, ep, 5'h0, 9'(n), 2'h0});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rdc("control", HCC_OFF, 32'h0);
    rdc("base", SIDB_OFF, 32'h0);
    rdc("count", SIDC_OFF, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    ahb(SIDB_OFF, 1'b1, 32'hffffffff);
    rdc("base", SIDB_OFF, 32'hfffff800);
    ahb(SIDC_OFF, 1'b1, 32'hffffffff);
    rdc("count ro", SIDC_OFF, 32'h0);
    ahb(HCC_OFF, 1'b1, 32'h0004ffff);
    rdc("control", HCC_OFF, 32'h00040000);
    chk("ewa", 32'h1, {31'h0, early_write_ack});
    chk("link off", 32'h0, {31'h0, link_connected});
    $display("test registers done");
  endtask

  task automatic t_link_off;
    scl_phy_model_i.frame(2, 1'b0);
    chk("writes", 32'h0, scl_phy_model_i.got_q.size());
    rdc("count", SIDC_OFF, 32'h0);
    $display("test link off done");
  endtask

  task automatic t_capture;
    ahb(HCC_OFF, 1'b1, 32'h00060000);
    // the write lands on the edge the task returns on; look one edge later
    @(posedge hclk);
    chk("link on", 32'h1, {31'h0, link_connected});
    ahb(SIDB_OFF, 1'b1, 32'h00012800);
    run(3, 1'b0, 1'b1, 8'h01);
    run(5, 1'b1, 1'b0, 8'h02);
    run(2, 1'b0, 1'b1, 8'h03);
    scl_phy_model_i.err_pulse();
    rdc("host fault", SIDC_OFF, 32'h80030008);
    run(1, 1'b0, 1'b0, 8'h04);
    $display("test capture done");
  endtask

  task automatic t_wrap;
    int k;
    for (k = 0; k < 256; k++) scl_phy_model_i.pulse(scl_link_evt_s'(4'b1000));
    ahb(SIDC_OFF, 1'b0, 32'h0);
    chk("epoch wrap", 32'h04, {24'h0, rd[23:16]});
    $display("test epoch wrap done");
  endtask

  // link and ewa written together with the reset bit are discarded
  task automatic t_soft;
    ahb(HCC_OFF, 1'b1, 32'h00070000);
    rdc("busy", HCC_OFF, 32'h00010000);
    chk("link", 32'h0, {31'h0, link_connected});
    repeat (4) @(posedge hclk);
    rdc("control", HCC_OFF, 32'h0);
    rdc("base", SIDB_OFF, 32'h0);
    rdc("count", SIDC_OFF, 32'h0);
    $display("test soft reset done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // the tests need under a thousand cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    $display("[FAIL] watchdog expected end seen timeout");
    print_verdict();
  end

  initial begin
    miscompares = 0;
    n_checks    = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    rd          = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_link_off();
    t_capture();
    t_wrap();
    t_soft();
    print_verdict();
  end
endmodule
